// [rtl/flash_prot_core.sv]
// Serial-flash command logic: block/sector lock, lock status, global lock,
// write-enable latch and the discoverable-parameter table read-out.
// Assumes mode-0 serial link, chip select high for at least CS_HIGH_MIN_NS.
//
// Behaviour
// - Single lock/unlock ignored without protect mode.
// - Lock 36h, unlock 39h, three address bytes.
// - Block from A16 up, sector from A12.
// - Lock sets read-only, unlock clears addressed only.
// - Single lock ends on byte boundary or rejected.
// - Status read 3Ch, address, status until deselect.
// - Status bit sits in first read-out byte.
// - Status one protected, zero writable.
// - Status read needs protect mode selected.
// - Global lock 7Eh, unlock 98h, opcode only.
// - Global lock sets all, unlock clears all.
// - Global command off boundary leaves protection unchanged.
// - Table read 5Ah, address, dummy, then stream.
// - Deselect ends table read at any point.
// - Revisions 00h/01h, byte 07h reads FFh.
// - Byte 06h gives header count minus one.
// - First header: ID 00h, 09h dwords, 30h.
// - Second header: vendor ID, 04h dwords, 60h.
// - Protect select sets mode bit permanently.
// - Power-up in protect mode locks everything.
`default_nettype none

module flash_prot_core
  import flash_prot_pkg::*;
(
  input  wire logic i_core_clk,       // Core clock, 10 MHz
  input  wire logic i_arst_n,         // Asynchronous reset, active low
  input  wire logic i_ce,             // Core clock enable
  input  wire logic i_sclk,           // Serial clock from host
  input  wire logic i_cs_n,           // Chip select, active low
  input  wire logic i_si,             // Serial data in
  input  wire logic i_protect_nv,     // Stored protect-mode bit at power-up
  input  wire logic i_protect_select, // Protect-mode select command pulse
  output var  logic o_so,             // Serial data out
  output var  logic o_so_oe,          // Serial data out enable
  output var  logic o_protect_mode,   // Individual-protect mode selected
  output var  logic o_write_enabled,  // Write-enable latch
  output var  logic o_prot_done,      // Protection change executed pulse
  output var  logic o_prot_reject     // Protection command rejected pulse
);
  import flash_prot_pkg::*;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------

  // Lock bit of an address: sectors in end blocks, whole middle blocks
  function automatic logic [5:0] lock_index(input logic [23:0] a);
    logic [2:0] blk;
    logic [3:0] sec;
    blk = a[TOP_ADDRESS_BIT:BLOCK_LSB];
    sec = a[BLOCK_LSB-1:SECTOR_LSB];
    if (blk == BLOCK_FIRST) begin
      lock_index = {2'h0, sec};
    end else if (blk == BLOCK_LAST) begin
      lock_index = LAST_SECT_BASE + {2'h0, sec};
    end else begin
      lock_index = MID_BLOCK_BASE + {3'h0, blk};
    end
  endfunction : lock_index

  // Parameter table byte at an address
  function automatic logic [7:0] table_byte(input logic [23:0] a);
    logic [7:0] b;
    b = UNUSED_BYTE;
    if (a[23:8] == 16'h0000) begin
      unique case (a[7:0])
        8'h00: b = SIG_B0;
        8'h01: b = SIG_B1;
        8'h02: b = SIG_B2;
        8'h03: b = SIG_B3;
        8'h04: b = REV_MINOR;
        8'h05: b = REV_MAJOR;
        8'h06: b = NUM_HEADERS_M1;
        8'h08: b = HDR0_ID;
        8'h09: b = REV_MINOR;
        8'h0a: b = REV_MAJOR;
        8'h0b: b = HDR0_LEN_DW;
        8'h0c: b = HDR0_PTR_LO;
        8'h0d: b = PTR_UPPER;
        8'h0e: b = PTR_UPPER;
        8'h10: b = VENDOR_ID;
        8'h11: b = REV_MINOR;
        8'h12: b = REV_MAJOR;
        8'h13: b = HDR1_LEN_DW;
        8'h14: b = HDR1_PTR_LO;
        8'h15: b = PTR_UPPER;
        8'h16: b = PTR_UPPER;
        default: b = UNUSED_BYTE;
      endcase
    end
    table_byte = b;
  endfunction : table_byte

  // ----------------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------------

  // Link frame state, cleared whenever chip select is high
  typedef struct packed {
    logic        started;
    logic [2:0]  bit_cnt;
    logic [2:0]  bytes;
    logic [6:0]  sh;
    logic [7:0]  op;
    logic [23:0] addr;
    logic        wp_m;
    logic        wp_s;
  } frame_s;

  // Last frame as seen at chip-select rise, kept across frames
  typedef struct packed {
    logic        seq;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [2:0]  bytes;
    logic        partial;
  } capture_s;

  // Serial output stage, falling edge
  typedef struct packed {
    logic so;
    logic oe;
  } out_s;

  // Core-side state
  typedef struct packed {
    logic                 cs_m;
    logic                 cs_s;
    logic                 cs_d;
    logic                 seen_seq;
    logic                 nv_done;
    logic                 individual_protect_select;
    logic                 wel;
    logic [LOCK_BITS-1:0] locks;
    logic                 done;
    logic                 rej;
  } core_s;

  frame_s   fr_r, fr_nxt;
  capture_s cp_r, cp_nxt;
  out_s     ou_r, ou_nxt;
  core_s    st_r, st_nxt;
  logic     link_rst_n;
  logic [7:0] nb;
  logic     cs_rise;
  logic     is_single;
  logic     is_global;
  logic     single_ok;
  logic     global_ok;
  logic [5:0] cap_idx;

  // Frame logic resets at every deselect, so a frame starts clean
  assign link_rst_n = i_arst_n & ~i_cs_n;

  // ----------------------------------------------------------------------
  // Link domain: command, address and dummy bytes on rising edges
  // ----------------------------------------------------------------------

  // Byte assembly and frame capture
  always_comb begin
    fr_nxt = fr_r;
    cp_nxt = cp_r;
    nb = {fr_r.sh, i_si};
    fr_nxt.sh = nb[6:0];
    fr_nxt.bit_cnt = fr_r.bit_cnt + 3'h1;
    fr_nxt.wp_m = st_r.individual_protect_select;
    fr_nxt.wp_s = fr_r.wp_m;
    if (!fr_r.started) begin
      fr_nxt.started = 1'b1;
      cp_nxt.seq = ~cp_r.seq;
    end
    if (fr_r.bit_cnt == 3'h7) begin
      if (fr_r.bytes == 3'h0) begin
        fr_nxt.op = nb;
      end else if (fr_r.bytes < BYTES_WITH_ADDR) begin
        fr_nxt.addr = {fr_r.addr[15:0], nb};
      end else if (fr_r.op == OP_READ_PARAM_TABLE && fr_r.bytes >= BYTES_SFDP_HEAD) begin
        fr_nxt.addr = fr_r.addr + 24'h000001;
      end
      if (fr_r.bytes != BYTES_SATURATE) begin
        fr_nxt.bytes = fr_r.bytes + 3'h1;
      end
    end
    cp_nxt.op = fr_nxt.op;
    cp_nxt.addr = fr_nxt.addr;
    cp_nxt.bytes = fr_nxt.bytes;
    cp_nxt.partial = (fr_nxt.bit_cnt != 3'h0);
  end

  // Frame registers
  always_ff @(posedge i_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fr_r <= '0;
    end else begin
      fr_r <= fr_nxt;
    end
  end

  // Capture registers, read by the core only while chip select is high
  always_ff @(posedge i_sclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cp_r <= '0;
    end else begin
      cp_r <= cp_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: read-out on falling edges
  // ----------------------------------------------------------------------

  // Lock status or table byte, most significant bit first
  always_comb begin
    logic [7:0] ob;
    logic       rd_status;
    logic       rd_table;
    ob = 8'h00;
    rd_status = (fr_r.op == OP_READ_BLOCK_STATUS) && (fr_r.bytes >= BYTES_WITH_ADDR)
                && fr_r.wp_s;
    rd_table = (fr_r.op == OP_READ_PARAM_TABLE) && (fr_r.bytes >= BYTES_SFDP_HEAD);
    if (rd_status) begin
      ob = {7'h00, st_r.locks[lock_index(fr_r.addr)]};
    end else if (rd_table) begin
      ob = table_byte(fr_r.addr);
    end
    ou_nxt.so = ob[3'h7 - fr_r.bit_cnt];
    ou_nxt.oe = rd_status | rd_table;
  end

  // Output stage, cleared by deselect
  always_ff @(negedge i_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ou_r <= '0;
    end else begin
      ou_r <= ou_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Core domain: execution at chip-select rise
  // ----------------------------------------------------------------------

  // Decode of the captured frame
  assign cs_rise   = st_r.cs_s & ~st_r.cs_d & (cp_r.seq != st_r.seen_seq);
  assign is_single = (cp_r.op == OP_SINGLE_BLOCK_LOCK) || (cp_r.op == OP_SINGLE_BLOCK_UNLK);
  assign is_global = (cp_r.op == OP_GLOBAL_LOCK) || (cp_r.op == OP_GLOBAL_UNLOCK);
  assign single_ok = !cp_r.partial && (cp_r.bytes == BYTES_WITH_ADDR);
  assign global_ok = !cp_r.partial && (cp_r.bytes == BYTES_OPCODE_ONLY);
  assign cap_idx   = lock_index(cp_r.addr);

  // Next core state
  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_m = i_cs_n;
    st_nxt.cs_s = st_r.cs_m;
    st_nxt.cs_d = st_r.cs_s;
    st_nxt.done = 1'b0;
    st_nxt.rej = 1'b0;
    if (!st_r.nv_done) begin
      st_nxt.nv_done = 1'b1;
      st_nxt.individual_protect_select = i_protect_nv;
    end else if (i_protect_select && st_r.wel) begin
      st_nxt.individual_protect_select = 1'b1;
      st_nxt.wel = 1'b0;
    end
    if (cs_rise) begin
      st_nxt.seen_seq = cp_r.seq;
      if (cp_r.op == OP_WRITE_ENABLE_CMD && global_ok) begin
        st_nxt.wel = 1'b1;
      end else if ((is_single || is_global) && st_r.individual_protect_select) begin
        st_nxt.wel = 1'b0;
        if (st_r.wel && is_single && single_ok) begin
          st_nxt.locks[cap_idx] = (cp_r.op == OP_SINGLE_BLOCK_LOCK);
          st_nxt.done = 1'b1;
        end else if (st_r.wel && is_global && global_ok) begin
          st_nxt.locks = (cp_r.op == OP_GLOBAL_LOCK) ? LOCKS_RESET : '0;
          st_nxt.done = 1'b1;
        end else begin
          st_nxt.rej = 1'b1;
        end
      end
    end
  end

  // Core registers; locks start set so protect mode powers up locked
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '{cs_m: 1'b1, cs_s: 1'b1, cs_d: 1'b1, seen_seq: 1'b0, nv_done: 1'b0,
                individual_protect_select: 1'b0, wel: 1'b0, locks: LOCKS_RESET, done: 1'b0, rej: 1'b0};
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign o_so            = ou_r.so;
  assign o_so_oe         = ou_r.oe;
  assign o_protect_mode  = st_r.individual_protect_select;
  assign o_write_enabled = st_r.wel;
  assign o_prot_done     = st_r.done;
  assign o_prot_reject   = st_r.rej;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  a_lock_needs_mode: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_ce && cs_rise && is_single && !st_r.individual_protect_select) |=> $stable(st_r.locks) && !st_r.rej)
    else $error("lock changed outside protect mode");

  a_single_lock_set: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_ce && cs_rise && st_r.individual_protect_select && st_r.wel && single_ok
     && cp_r.op == OP_SINGLE_BLOCK_LOCK) |=> st_r.locks[$past(cap_idx)] && st_r.done)
    else $error("single lock did not set the bit");

  a_single_unlock_clr: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_ce && cs_rise && st_r.individual_protect_select && st_r.wel && single_ok
     && cp_r.op == OP_SINGLE_BLOCK_UNLK)
    |=> !st_r.locks[$past(cap_idx)] && $countones(st_r.locks ^ $past(st_r.locks)) <= 1)
    else $error("single unlock wrong");

  a_partial_reject: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_ce && cs_rise && st_r.individual_protect_select && is_single && cp_r.partial)
    |=> st_r.rej && $stable(st_r.locks))
    else $error("partial lock frame executed");

  a_global_lock_all: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_ce && cs_rise && st_r.individual_protect_select && st_r.wel && global_ok
     && cp_r.op == OP_GLOBAL_LOCK) |=> (&st_r.locks) ##1 (!st_r.done || !i_ce))
    else $error("global lock did not set all");

  a_global_unlock: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_ce && cs_rise && st_r.individual_protect_select && st_r.wel && global_ok
     && cp_r.op == OP_GLOBAL_UNLOCK) |=> st_r.locks == '0)
    else $error("global unlock did not clear all");

  a_global_bad_edge: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_ce && cs_rise && st_r.individual_protect_select && is_global && !global_ok)
    |=> $stable(st_r.locks) && st_r.rej)
    else $error("global command off boundary executed");

  a_wel_cleared: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_ce && cs_rise && st_r.individual_protect_select && (is_single || is_global)) |=> !st_r.wel)
    else $error("write enable kept after lock command");

  a_mode_sticky: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (st_r.nv_done && st_r.individual_protect_select) |=> st_r.individual_protect_select)
    else $error("protect mode cleared");

  a_powerup_locked: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (!st_r.nv_done && i_ce && !cs_rise) |=> (&st_r.locks))
    else $error("blocks not locked at power-up");

endmodule : flash_prot_core

`default_nettype wire

// [rtl/flash_prot_pkg.sv]
// Constants for the serial-flash block protection and parameter-table logic.
// Assumes a mode-0 serial link and a 4 Mbit array (address bits 18 down to 0).
`default_nettype none

package flash_prot_pkg;

  // ----------------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE_CMD   = 8'h06;
  localparam logic [7:0] OP_SINGLE_BLOCK_LOCK  = 8'h36;
  localparam logic [7:0] OP_SINGLE_BLOCK_UNLK  = 8'h39;
  localparam logic [7:0] OP_READ_BLOCK_STATUS  = 8'h3c;
  localparam logic [7:0] OP_GLOBAL_LOCK        = 8'h7e;
  localparam logic [7:0] OP_GLOBAL_UNLOCK      = 8'h98;
  localparam logic [7:0] OP_READ_PARAM_TABLE   = 8'h5a;

  // ----------------------------------------------------------------------
  // Frame lengths in whole bytes
  // ----------------------------------------------------------------------
  localparam logic [2:0] BYTES_OPCODE_ONLY = 3'h1;
  localparam logic [2:0] BYTES_WITH_ADDR   = 3'h4;
  localparam logic [2:0] BYTES_SFDP_HEAD   = 3'h5;
  localparam logic [2:0] BYTES_SATURATE    = 3'h7;

  // ----------------------------------------------------------------------
  // Array layout: block field and sector field of the address
  // ----------------------------------------------------------------------
  localparam int         TOP_ADDRESS_BIT = 18;
  localparam int         BLOCK_LSB       = 16;
  localparam int         SECTOR_LSB      = 12;
  localparam logic [2:0] BLOCK_FIRST     = 3'h0;
  localparam logic [2:0] BLOCK_LAST      = 3'h7;
  localparam int         LOCK_BITS       = 38;
  localparam logic [5:0] LAST_SECT_BASE  = 6'h10;
  localparam logic [5:0] MID_BLOCK_BASE  = 6'h1f;
  localparam logic [LOCK_BITS-1:0] LOCKS_RESET = {LOCK_BITS{1'b1}};

  // ----------------------------------------------------------------------
  // Parameter table contents
  // ----------------------------------------------------------------------
  localparam logic [7:0] SIG_B0 = 8'h53;
  localparam logic [7:0] SIG_B1 = 8'h46;
  localparam logic [7:0] SIG_B2 = 8'h44;
  localparam logic [7:0] SIG_B3 = 8'h50;
  localparam logic [7:0] REV_MINOR      = 8'h00;
  localparam logic [7:0] REV_MAJOR      = 8'h01;
  localparam logic [7:0] NUM_HEADERS_M1 = 8'h01;
  localparam logic [7:0] UNUSED_BYTE    = 8'hff;
  localparam logic [7:0] HDR0_ID        = 8'h00;
  localparam logic [7:0] HDR0_LEN_DW    = 8'h09;
  localparam logic [7:0] HDR0_PTR_LO    = 8'h30;
  localparam logic [7:0] HDR1_LEN_DW    = 8'h04;
  localparam logic [7:0] HDR1_PTR_LO    = 8'h60;
  localparam logic [7:0] PTR_UPPER      = 8'h00;
  // Vendor identification code, value arbitrary
  localparam logic [7:0] VENDOR_ID      = 8'h3e;

  // Least chip-select high time assumed between frames
  localparam int CS_HIGH_MIN_NS = 400;

endpackage : flash_prot_pkg

`default_nettype wire

// [test/spi_host_model.sv]
// Host serial controller model: drives mode-0 frames onto the link.
// Assumes the device samples input on rising clock and shifts out on falling.
`default_nettype none

module spi_host_model (
  output var  logic o_sclk,  // Serial clock, still outside frames
  output var  logic o_cs_n,  // Chip select, active low
  output var  logic o_si,    // Serial data to device
  input  wire logic i_so,    // Serial data from device
  input  wire logic i_so_oe  // Device drives serial out
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF = 6;  // Half of the 12 ns link period

  // ----------------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------------
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end

  // One frame: nbits of tx MSB first, then nrd bits read back
  task automatic frame(input int nbits, input logic [63:0] tx, input int nrd,
                       output logic [127:0] rx, output logic oe_any);
    rx     = '0;
    oe_any = 1'b0;
    #(HALF + 1);
    o_cs_n = 1'b0;
    for (int b = 0; b < nbits; b++) begin
      o_si = tx[63-b];
      #HALF o_sclk = 1'b1;
      #HALF o_sclk = 1'b0;
    end
    for (int b = 0; b < nrd; b++) begin
      o_si = ~o_si;  // Input carries nothing while reading
      #HALF o_sclk = 1'b1;
      rx     = {rx[126:0], i_so};
      oe_any = oe_any | i_so_oe;
      #HALF o_sclk = 1'b0;
    end
    #HALF o_cs_n = 1'b1;
    o_si = ~o_si;  // Released line does not keep its last value
  endtask : frame

endmodule : spi_host_model

`default_nettype wire

// [test/test_spi_flash_block_lock_sfdp.sv]
// Self-checking bench for the block-lock and parameter-table logic.
// Assumes flash_prot_pkg, flash_prot_core and the host model spi_host_model.
`default_nettype none

module test_spi_flash_block_lock_sfdp;
  import flash_prot_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 i_core_clk       = 1'b0;
  logic                 i_arst_n         = 1'b0;
  logic                 i_ce             = 1'b1;
  logic                 i_protect_nv     = 1'b0;
  logic                 i_protect_select = 1'b0;
  wire logic            sclk, cs_n, si, so, so_oe, mode, wel, done, rej;
  int                   err_total   = 0;
  int                   checks_done = 0;
  int                   n_done      = 0;
  int                   n_rej       = 0;
  int                   seed        = 32'h9c44c49e;
  logic                 exp_mode;
  logic [LOCK_BITS-1:0] lk;
  // Parameter table bytes 00h..17h, byte 10h is taken from the vendor code
  localparam logic [191:0] TBL = {64'h5346_4450_0001_01ff, 64'h0000_0109_3000_00ff,
                                  64'h0000_0104_6000_00ff};

  always #50 i_core_clk = ~i_core_clk;

  flash_prot_core u_dut (
    .i_core_clk       (i_core_clk),
    .i_arst_n         (i_arst_n),
    .i_ce             (i_ce),
    .i_sclk           (sclk),
    .i_cs_n           (cs_n),
    .i_si             (si),
    .i_protect_nv     (i_protect_nv),
    .i_protect_select (i_protect_select),
    .o_so             (so),
    .o_so_oe          (so_oe),
    .o_protect_mode   (mode),
    .o_write_enabled  (wel),
    .o_prot_done      (done),
    .o_prot_reject    (rej)
  );

  spi_host_model u_host (
    .o_sclk  (sclk),
    .o_cs_n  (cs_n),
    .o_si    (si),
    .i_so    (so),
    .i_so_oe (so_oe)
  );

  // Count one-cycle execute and reject pulses, sampled mid-cycle where settled
  always @(negedge i_core_clk) begin
    if (done === 1'b1) n_done++;
    if (rej === 1'b1) n_rej++;
  end

  // ----------------------------------------------------------------------
  // Expectation helpers
  // ----------------------------------------------------------------------
  function automatic int idx(input logic [23:0] a);
    if (a[18:16] == 3'h0) return int'(a[15:12]);
    if (a[18:16] == 3'h7) return 16 + int'(a[15:12]);
    return 31 + int'(a[18:16]);
  endfunction : idx

  function automatic logic [7:0] tbl(input int a);
    if (a > 23) return 8'hff;
    if (a == 16) return VENDOR_ID;
    return TBL[8*(23-a) +: 8];
  endfunction : tbl

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // ----------------------------------------------------------------------
  // Link transactions
  // ----------------------------------------------------------------------
  task automatic cmd(input int nb, input logic [63:0] tx);
    logic [127:0] rx;
    logic         oe;
    u_host.frame(nb, tx, 0, rx, oe);
    repeat (8) @(negedge i_core_clk);
  endtask : cmd

  task automatic write_enable_cmd();
    cmd(8, {OP_WRITE_ENABLE_CMD, 56'h0});
  endtask : write_enable_cmd

  task automatic lockcmd(input logic [7:0] op, input logic [23:0] a, input int nb,
                         input logic wr, input logic ok);
    int d0;
    int r0;
    if (wr) write_enable_cmd();
    d0 = n_done;
    r0 = n_rej;
    cmd(nb, {op, a, 32'h0});
    chk("done_pulse", n_done - d0, ok);
    chk("reject_pulse", n_rej - r0, exp_mode & ~ok);
    chk("write_enable", wel, ~exp_mode & wr);
    if (ok) begin
      case (op)
        OP_SINGLE_BLOCK_LOCK: lk[idx(a)] = 1'b1;
        OP_SINGLE_BLOCK_UNLK: lk[idx(a)] = 1'b0;
        OP_GLOBAL_LOCK:       lk = '1;
        default:              lk = '0;
      endcase
    end
  endtask : lockcmd

  task automatic rdstat(input logic [23:0] a);
    logic [127:0] rx;
    logic         oe;
    u_host.frame(32, {OP_READ_BLOCK_STATUS, a, 32'h0}, 16, rx, oe);
    repeat (8) @(negedge i_core_clk);
    chk("status_oe", oe, exp_mode);
    if (exp_mode) chk("status", rx[15:0], {2{7'h00, lk[idx(a)]}});
  endtask : rdstat

  task automatic sfdp(input logic [23:0] a, input int n);
    logic [127:0] rx;
    logic         oe;
    u_host.frame(40, {OP_READ_PARAM_TABLE, a, 8'h00, 24'h0}, 8 * n, rx, oe);
    repeat (8) @(negedge i_core_clk);
    for (int k = 0; k < n; k++)
      chk("table_byte", rx[8*(n-1-k) +: 8], tbl(int'(a) + k));
  endtask : sfdp

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  // Watchdog against a hung handshake
  initial begin
    #2_000_000;
    err_total++;
    results();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [23:0]  a;
    logic [7:0]   op;
    logic [127:0] rx;
    logic         oe;
    logic [7:0]   ops [4] = '{OP_SINGLE_BLOCK_LOCK, OP_SINGLE_BLOCK_UNLK, OP_GLOBAL_LOCK,
                              OP_GLOBAL_UNLOCK};
    logic [23:0]  edge_a [7] = '{24'h000000, 24'h00f000, 24'h010000, 24'h06ffff,
                                 24'h070000, 24'h07f000, 24'hf8f000};
    exp_mode = 1'b0;
    lk       = '1;
    repeat (16) @(negedge i_core_clk);
    i_arst_n = 1'b1;
    repeat (4) @(negedge i_core_clk);
    // Lock family ignored before protect mode
    chk("mode", mode, 1'b0);
    foreach (ops[i]) lockcmd(ops[i], 24'h010000, 32, 1'b1, 1'b0);
    rdstat(24'h020000);
    // Select pulse while the core is frozen has no effect
    write_enable_cmd();
    i_ce             = 1'b0;
    i_protect_select = 1'b1;
    @(negedge i_core_clk);
    i_protect_select = 1'b0;
    i_ce             = 1'b1;
    repeat (2) @(negedge i_core_clk);
    chk("frozen_mode", mode, 1'b0);
    chk("frozen_wel", wel, 1'b1);
    $display("test no_protect finished");
    // Select individual protect mode
    write_enable_cmd();
    i_protect_select = 1'b1;
    @(negedge i_core_clk);
    i_protect_select = 1'b0;
    repeat (4) @(negedge i_core_clk);
    exp_mode = 1'b1;
    chk("mode", mode, 1'b1);
    chk("write_enable", wel, 1'b0);
    // Boundary addresses locked then unlocked one by one
    lockcmd(OP_GLOBAL_UNLOCK, 24'h0, 8, 1'b1, 1'b1);
    for (int p = 0; p < 2; p++) begin
      foreach (edge_a[i]) begin
        lockcmd(p == 0 ? OP_SINGLE_BLOCK_LOCK : OP_SINGLE_BLOCK_UNLK, edge_a[i], 32, 1'b1,
                1'b1);
        foreach (edge_a[j]) rdstat(edge_a[j]);
      end
    end
    $display("test boundaries finished");
    // Random commands with status read-back
    for (int r = 0; r < 16; r++) begin
      a = 24'($random(seed));
      op = ops[{$random(seed)} % 4];
      // Global commands are the opcode alone, single ones carry an address
      lockcmd(op, a, (op == OP_GLOBAL_LOCK || op == OP_GLOBAL_UNLOCK) ? 8 : 32, 1'b1,
              1'b1);
      rdstat(a);
      rdstat(24'($random(seed)));
    end
    $display("test random finished");
    // Refused frames leave protection unchanged
    a = 24'($random(seed));
    lockcmd(OP_SINGLE_BLOCK_LOCK, a, 30, 1'b1, 1'b0);
    lockcmd(OP_SINGLE_BLOCK_UNLK, a, 36, 1'b1, 1'b0);
    lockcmd(OP_GLOBAL_LOCK, a, 9, 1'b1, 1'b0);
    lockcmd(OP_GLOBAL_UNLOCK, a, 16, 1'b1, 1'b0);
    lockcmd(OP_SINGLE_BLOCK_LOCK, a, 32, 1'b0, 1'b0);
    rdstat(a);
    foreach (edge_a[j]) rdstat(edge_a[j]);
    $display("test refusals finished");
    // Parameter table, early deselect, random start
    sfdp(24'h0, 16);
    sfdp(24'h10, 10);
    u_host.frame(40, {OP_READ_PARAM_TABLE, 24'h000003, 32'h0}, 5, rx, oe);
    repeat (8) @(negedge i_core_clk);
    chk("abort_bits", rx[4:0], 5'h0a);
    chk("abort_oe", so_oe, 1'b0);
    sfdp(24'({$random(seed)} % 20), 6);
    $display("test table finished");
    // Reset in mid-run with the stored mode bit set
    i_arst_n     = 1'b0;
    i_protect_nv = 1'b1;
    repeat (2) @(negedge i_core_clk);
    i_arst_n = 1'b1;
    repeat (4) @(negedge i_core_clk);
    lk = '1;
    chk("mode", mode, 1'b1);
    chk("write_enable", wel, 1'b0);
    foreach (edge_a[j]) rdstat(edge_a[j]);
    $display("test power_up finished");
    results();
  end

endmodule : test_spi_flash_block_lock_sfdp

`default_nettype wire
